//--- rtl/sfp_pkg.sv
// Purpose: shared constants and types of the initiator fifo port
// Assumes: 16-bit registers in the low half of a 32-bit bus word
// Notes:   one-hot state codes, fixed packet length of eight words
package sfp_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STAT   = 8'h04;
  localparam logic [7:0]  OFS_TGT    = 8'h08;
  localparam logic [7:0]  OFS_FIFO   = 8'h0C;
  localparam logic [15:0] CTRL_RST   = 16'h02F0;
  localparam logic [15:0] STAT_RST   = 16'h0001;
  localparam logic [15:0] TGT_RST    = 16'h0000;
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_BURST = 1;
  localparam int          CTRL_BYTE  = 2;
  localparam int          CTRL_NP    = 4;
  localparam int          CTRL_EP    = 8;
  localparam int          STAT_EMPTY = 0;
  localparam int          STAT_FULL  = 1;
  localparam int          STAT_ACT   = 2;
  localparam int          STAT_LAST  = 3;
  localparam int          STAT_INRQ  = 4;
  localparam int          STAT_OUTRQ = 5;
  // ==========================================================
  // link encodings and sizes
  localparam logic [1:0]  BE_WORD    = 2'b11;
  localparam logic [1:0]  BE_BYTE    = 2'b01;
  localparam logic [1:0]  CMD_READ   = 2'b01;
  localparam logic [1:0]  CMD_WRITE  = 2'b10;
  localparam int          DATA_W     = 16;
  localparam int          FIFO_D     = 8;
  localparam logic [3:0]  PKT_WORDS  = 4'h8;
  localparam logic [3:0]  ONE_WORD   = 4'h1;
  localparam logic [5:0]  PKT_BASE   = 6'h02;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_RSP  = 3'b100
  } sfp_state_t;
endpackage

//--- rtl/sfp_fifo_if.sv
// Purpose: carrier between the port controller and its word fifo
// Assumes: single clock domain
// Notes:   vin/vout move the whole fifo at once
`timescale 1ns/1ps
interface sfp_fifo_if #(parameter int W = 16, parameter int D = 8);
  logic               push;
  logic               pop;
  logic               clr;
  logic               vload;
  logic [W-1:0]       wdata;
  logic [W-1:0]       rdata;
  logic [$clog2(D):0] count;
  logic [D*W-1:0]     vin;
  logic [D*W-1:0]     vout;
  modport ctl (output push, pop, clr, vload, wdata, vin,
               input rdata, count, vout);
  modport mem (input push, pop, clr, vload, wdata, vin,
               output rdata, count, vout);
endinterface

//--- rtl/sfp_fifo.sv
// Purpose: eight-word flip-flop fifo with whole-vector load and view
// Assumes: depth is a power of two so pointers wrap naturally
// Notes:   clear wins over every other request
`timescale 1ns/1ps
module sfp_fifo
  import sfp_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int D = FIFO_D
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // storage side
  sfp_fifo_if.mem  f
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          do_push;
  logic          do_pop;

  assign do_push = f.push && (cnt_r != (AW+1)'(D));
  assign do_pop  = f.pop && (cnt_r != '0);
  assign f.count = cnt_r;
  assign f.rdata = mem_r[rp_r];

  // ==========================================================
  // pointers and level
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (f.clr)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (f.vload)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= (AW+1)'(D);
    end
    else
    begin
      if (do_push)
        wp_r <= wp_r + 1'b1;
      if (do_pop)
        rp_r <= rp_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // storage and vector view, oldest word in the low slice
  genvar i;
  generate
    for (i = 0; i < D; i++)
    begin : g_word
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          mem_r[i] <= '0;
        else if (f.vload)
          mem_r[i] <= f.vin[i*W +: W];
        else if (do_push && wp_r == AW'(i))
          mem_r[i] <= f.wdata;
      end
      assign f.vout[i*W +: W] = mem_r[AW'(rp_r + AW'(i))];
    end
  endgenerate
endmodule

//--- rtl/sfp_port.sv
// Purpose: initiator bridge from the core's register bus to a basic
//          valid/acknowledge link target, through an 8-word fifo
// Assumes: link target runs on sys_clk; request pins are asynchronous
// Notes:   fifo data reads while enabled hold off ack until a word is present
`timescale 1ns/1ps
// How it works
// - mode fields change only while disabled
// - burst length is 2*(count+1) packets
// - byte enables 11 for word or burst, 01 single byte
// - burst select: single word or packets
// - idle until core touches the fifo
// - normal read issues one read, stalls core
// - normal write into empty fifo sends one write
// - target address drives link, locked while active
// - burst read refills empty fifo, stalls core
// - last word flag sets, write one clears
// - full fifo in burst write drains out
// - active flag follows transfers and fifo words
// - full and empty flags track fifo exactly
// - usb request levels shown in status
// - endpoint index selects indexed usb registers
// - vector port moves whole fifo at once
// - no error detection or error status
// - acts only as link initiator
module sfp_port
  import sfp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // link command
  output logic             vci_cmdval,
  input  wire logic        vci_cmdack,
  output logic [5:0]       vci_address,
  output logic [1:0]       vci_be,
  output logic [1:0]       vci_cmd,
  output logic [15:0]      vci_wdata,
  output logic             vci_eop,
  // link response
  input  wire logic        vci_rspval,
  output logic             vci_rspack,
  input  wire logic [15:0] vci_rdata,
  // usb cell side
  input  wire logic        usb_out_request,
  input  wire logic        usb_in_request,
  output logic [1:0]       endpoint_index,
  // vectored bus
  input  wire logic        vec_load,
  input  wire logic [127:0] vec_wdata,
  input  wire logic        vec_take,
  output logic [127:0]     vec_rdata,
  output logic             vec_load_ok,
  output logic             vec_take_ok
);
  sfp_fifo_if #(.W(DATA_W), .D(FIFO_D)) f ();

  sfp_fifo u_fifo
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .f       (f)
  );

  logic             en_r;
  logic             burst_r;
  logic             byte_r;
  logic [3:0]       np_r;
  logic [1:0]       ep_r;
  logic [5:0]       tgt_r;
  logic             last_r;
  sfp_state_t       state_r;
  logic             is_rd_r;
  logic [3:0]       len_r;
  logic [3:0]       cmd_cnt_r;
  logic [3:0]       rsp_cnt_r;
  logic [5:0]       pk_left_r;
  logic             rd_msg_r;
  logic [1:0]       rq_s1_r;
  logic [1:0]       rq_s2_r;
  logic [31:0]      dat_r;
  logic             ack_r;
  logic [7:0]       adr;
  logic             wb_req;
  logic             go;
  logic             acc;
  logic             bus_push;
  logic             bus_pop;
  logic             start_rd;
  logic             start_wr;
  logic             auto_rd;
  logic             auto_wr;
  logic             vload_go;
  logic             vtake_go;
  logic             cmd_fire;
  logic             rsp_fire;
  logic             f_empty;
  logic             f_full;
  logic             active;
  logic             last_set;
  logic             last_clr;
  logic             ctrl_wr;
  logic             rd_pop_last;

  assign adr     = {wb_adr_i[7:2], 2'b00};
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign f_empty = (f.count == '0);
  assign f_full  = (f.count == 4'(FIFO_D));
  assign acc     = wb_req && go;

  // ==========================================================
  // fifo port access decision
  always_comb
  begin
    go       = 1'b1;
    bus_push = 1'b0;
    bus_pop  = 1'b0;
    start_rd = 1'b0;
    start_wr = 1'b0;
    if (wb_req && adr == OFS_FIFO && en_r)
    begin
      if (!wb_we_i)
      begin
        if (!f_empty && (state_r == ST_IDLE || is_rd_r))
          bus_pop = 1'b1;
        else
        begin
          go = 1'b0;
          if (state_r == ST_IDLE && f_empty && !(burst_r && rd_msg_r))
            start_rd = 1'b1;
        end
      end
      else if (!burst_r)
      begin
        if (state_r != ST_IDLE)
          go = 1'b0;
        else if (f_empty)
        begin
          bus_push = 1'b1;
          start_wr = 1'b1;
        end
      end
      else if (!rd_msg_r)
      begin
        if (f_full)
          go = 1'b0;
        else
          bus_push = 1'b1;
      end
    end
  end

  assign auto_rd  = en_r && burst_r && rd_msg_r && state_r == ST_IDLE
                    && f_empty && pk_left_r != '0;
  assign auto_wr  = en_r && burst_r && !rd_msg_r && state_r == ST_IDLE
                    && f_full;
  assign vload_go = vec_load && en_r && burst_r && !rd_msg_r && f_empty
                    && state_r == ST_IDLE;
  assign vtake_go = vec_take && en_r && f_full && is_rd_r
                    && state_r == ST_IDLE;
  assign vec_load_ok = en_r && burst_r && !rd_msg_r && f_empty
                       && state_r == ST_IDLE;
  assign vec_take_ok = en_r && f_full && is_rd_r && state_r == ST_IDLE;
  assign vec_rdata   = f.vout;

  assign cmd_fire = vci_cmdval && vci_cmdack;
  assign rsp_fire = vci_rspval && vci_rspack && state_r != ST_IDLE;

  assign f.push  = bus_push || (rsp_fire && is_rd_r);
  assign f.wdata = bus_push ? wb_dat_i[15:0]
                 : (byte_r && !burst_r) ? {8'h00, vci_rdata[7:0]}
                 : vci_rdata;
  assign f.pop   = bus_pop || (cmd_fire && !is_rd_r);
  assign f.clr   = !en_r || vtake_go;
  assign f.vload = vload_go;
  assign f.vin   = vec_wdata;

  // ==========================================================
  // link command and response signalling
  assign vci_cmdval  = (state_r == ST_CMD);
  assign vci_address = tgt_r;
  assign vci_be      = (!burst_r && byte_r) ? BE_BYTE : BE_WORD;
  assign vci_cmd     = is_rd_r ? CMD_READ : CMD_WRITE;
  // reads push into the fifo while a command waits, so park write data
  assign vci_wdata   = is_rd_r ? 16'h0000 : f.rdata;
  assign vci_eop     = (cmd_cnt_r == len_r - 1'b1);
  // responses carry no error handling, target may answer at once
  assign vci_rspack  = 1'b1;

  // ==========================================================
  // transfer engine
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r   <= ST_IDLE;
      is_rd_r   <= 1'b0;
      len_r     <= ONE_WORD;
      cmd_cnt_r <= '0;
      rsp_cnt_r <= '0;
    end
    else if (!en_r)
      state_r <= ST_IDLE;
    else
    begin
      if (cmd_fire)
        cmd_cnt_r <= cmd_cnt_r + 1'b1;
      if (rsp_fire)
        rsp_cnt_r <= rsp_cnt_r + 1'b1;
      unique case (state_r)
        ST_IDLE:
        begin
          if (start_rd || start_wr || auto_rd || auto_wr)
          begin
            state_r   <= ST_CMD;
            is_rd_r   <= start_rd || auto_rd;
            len_r     <= burst_r ? PKT_WORDS : ONE_WORD;
            cmd_cnt_r <= '0;
            rsp_cnt_r <= '0;
          end
        end
        ST_CMD:
        begin
          // command stays put until the target takes it
          if (cmd_fire && vci_eop)
            state_r <= ST_RSP;
        end
        ST_RSP:
        begin
          if (rsp_fire && rsp_cnt_r == len_r - 1'b1)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // burst read message tracking
  assign rd_pop_last = rd_msg_r && pk_left_r == '0
                       && state_r == ST_IDLE
                       && ((bus_pop && f.count == 4'h1) || vtake_go);
  assign last_set    = rd_pop_last;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_msg_r  <= 1'b0;
      pk_left_r <= '0;
    end
    else if (!en_r || rd_pop_last)
      rd_msg_r <= 1'b0;
    else if (start_rd && burst_r)
    begin
      rd_msg_r  <= 1'b1;
      pk_left_r <= {1'b0, np_r, 1'b0} + PKT_BASE - 6'h01;
    end
    else if (auto_rd)
      pk_left_r <= pk_left_r - 6'h01;
  end

  // ==========================================================
  // control, target and status registers
  assign ctrl_wr  = acc && wb_we_i && adr == OFS_CTRL;
  assign last_clr = acc && wb_we_i && adr == OFS_STAT && wb_sel_i[0]
                    && wb_dat_i[STAT_LAST];
  assign active   = en_r && (state_r != ST_IDLE || rd_msg_r
                    || !f_empty);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_r    <= CTRL_RST[CTRL_EN];
      burst_r <= CTRL_RST[CTRL_BURST];
      byte_r  <= CTRL_RST[CTRL_BYTE];
      np_r    <= CTRL_RST[CTRL_NP +: 4];
      ep_r    <= CTRL_RST[CTRL_EP +: 2];
    end
    else if (ctrl_wr)
    begin
      if (wb_sel_i[0])
      begin
        en_r <= wb_dat_i[CTRL_EN];
        if (!en_r)
        begin
          burst_r <= wb_dat_i[CTRL_BURST];
          byte_r  <= wb_dat_i[CTRL_BYTE];
          np_r    <= wb_dat_i[CTRL_NP +: 4];
        end
      end
      if (wb_sel_i[1])
        ep_r <= wb_dat_i[CTRL_EP +: 2];
    end
  end

  assign endpoint_index = ep_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      tgt_r <= TGT_RST[5:0];
    else if (acc && wb_we_i && adr == OFS_TGT && wb_sel_i[0] && !active)
      tgt_r <= wb_dat_i[5:0];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      last_r <= STAT_RST[STAT_LAST];
    else if (last_set)
      last_r <= 1'b1;
    else if (last_clr)
      last_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rq_s1_r <= '0;
      rq_s2_r <= '0;
    end
    else
    begin
      rq_s1_r <= {usb_out_request, usb_in_request};
      rq_s2_r <= rq_s1_r;
    end
  end

  // ==========================================================
  // bus answer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end
    else
    begin
      ack_r <= acc;
      if (acc && !wb_we_i)
      begin
        unique case (adr)
          OFS_CTRL: dat_r <= {16'h0000, 6'h00, ep_r, np_r, 1'b0,
                              byte_r, burst_r, en_r};
          OFS_STAT: dat_r <= {16'h0000, 10'h000, rq_s2_r, last_r,
                              active, f_full, f_empty};
          OFS_TGT:  dat_r <= {16'h0000, 10'h000, tgt_r};
          OFS_FIFO: dat_r <= {16'h0000, f.rdata};
          default:  dat_r <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_byte_enable: assert property (
    vci_cmdval |-> vci_be == ((!burst_r && byte_r) ? 2'b01 : 2'b11))
    else $error("byte enables do not follow width mode");
  a_cmd_hold: assert property (
    vci_cmdval && !vci_cmdack |=> vci_cmdval && $stable(vci_address)
      && $stable(vci_wdata) && $stable(vci_cmd))
    else $error("command changed before acceptance");
  a_cfg_locked: assert property (
    en_r |=> $stable(np_r) && $stable(burst_r) && $stable(byte_r))
    else $error("mode field changed while enabled");
  a_tgt_locked: assert property (
    active |=> $stable(tgt_r))
    else $error("target address changed during transfer");
  a_flags_exact: assert property (
    dat_r[STAT_FULL] == 1'b1 && $past(acc) && $past(adr) == OFS_STAT
      && !$past(wb_we_i) |-> $past(f.count) == 4'h8)
    else $error("full flag read without a full fifo");
  a_last_sets: assert property (
    last_set |=> last_r ##1 (last_r || $past(last_clr)))
    else $error("last word flag not raised");
  a_idle_wait: assert property (
    state_r == ST_IDLE && !start_rd && !start_wr && !auto_rd
      && !auto_wr |=> !vci_cmdval)
    else $error("command issued without a fifo access");
  a_burst_drain: assert property (
    auto_wr |=> vci_cmdval && vci_cmd == 2'b10 ##0 vci_be == 2'b11)
    else $error("full burst fifo not sent");
  a_read_stall: assert property (
    en_r && wb_req && !wb_we_i && adr == OFS_FIFO && f_empty
      |=> !wb_ack_o)
    else $error("fifo read answered without data");
  a_burst_len: assert property (
    start_rd && burst_r |=> pk_left_r == {1'b0, $past(np_r), 1'b0}
      + 6'h01)
    else $error("packet count misloaded");

  c_norm_write: cover property (start_wr ##[1:20] state_r == ST_IDLE);
  c_last_word: cover property (last_set);
  c_vec_load: cover property (vload_go ##[1:30] f_empty);
  c_burst_rd: cover property (auto_rd);
endmodule

//--- verification/sfp_tgt_model.sv
// Purpose: behavioural link target facing the fifo port
// Assumes: runs on sys_clk beside the port
// Notes:   slow stalls command accept and response at random
`timescale 1ns/1ps
module sfp_tgt_model
  import sfp_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // command
  input wire logic        vci_cmdval,
  output logic            vci_cmdack,
  input wire logic [5:0]  vci_address,
  input wire logic [1:0]  vci_be,
  input wire logic [1:0]  vci_cmd,
  input wire logic [15:0] vci_wdata,
  input wire logic        vci_eop,
  // response
  output logic            vci_rspval,
  input wire logic        vci_rspack,
  output logic [15:0]     vci_rdata,
  // pacing
  input wire logic        slow
);
  // ==========================================
  // accepted writes and pending responses
  logic [24:0] wq[$];
  logic [15:0] rq[$];
  logic [15:0] nrd;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vci_cmdack <= 1'b0;
      vci_rspval <= 1'b0;
      vci_rdata  <= 16'h0000;
      nrd = 16'h0000;
      rq.delete();
    end
    else
    begin
      vci_cmdack <= !slow || 1'($urandom_range(1));
      if (vci_cmdval && vci_cmdack)
      begin
        if (vci_cmd == CMD_READ)
        begin
          rq.push_back(16'ha000 ^ nrd);
          nrd = nrd + 16'h0001;
        end
        else
        begin
          wq.push_back({vci_eop, vci_be, vci_address, vci_wdata});
          rq.push_back(16'h0000);
        end
      end
      if (vci_rspval && vci_rspack)
        void'(rq.pop_front());
      // a response stands until acknowledged, else the bus toggles
      if (!(vci_rspval && !vci_rspack))
      begin
        if (rq.size() > 0 && (!slow || 1'($urandom_range(1))))
        begin
          vci_rspval <= 1'b1;
          vci_rdata  <= rq[0];
        end
        else
        begin
          vci_rspval <= 1'b0;
          vci_rdata  <= ~vci_rdata;
        end
      end
    end
  end
endmodule

//--- verification/vci_initiator_fifo_port_tb_top.sv
// Purpose: self-checking bench of the initiator fifo port
// Assumes: register bus is classic single-cycle wishbone
// Notes:   link side answered by sfp_tgt_model
`timescale 1ns/1ps
module vci_initiator_fifo_port_tb_top
  import sfp_pkg::*;
();
  logic         sys_clk, rst_b, cyc, stb, we, slow, b;
  logic         vec_load, ld_ok, out_rq, in_rq, ack, vec_take, tk_ok;
  logic         cmdval, cmdack, eop, rspval, rspack;
  logic [7:0]   adr;
  logic [31:0]  dat_i, dat_o;
  logic [5:0]   vaddr, a;
  logic [1:0]   be, cmd, ep;
  logic [3:0]   np;
  logic [15:0]  wdata, rdata, q, d, nrd;
  logic [127:0] vw, vv, vr;
  logic [24:0]  ew[$];
  int           err_count, check_count, cyc_cnt, i, k, n;

  sfp_port uut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .vci_cmdval(cmdval), .vci_cmdack(cmdack), .vci_address(vaddr),
    .vci_be(be), .vci_cmd(cmd), .vci_wdata(wdata), .vci_eop(eop),
    .vci_rspval(rspval), .vci_rspack(rspack), .vci_rdata(rdata),
    .usb_out_request(out_rq), .usb_in_request(in_rq),
    .endpoint_index(ep), .vec_load(vec_load), .vec_wdata(vw),
    .vec_take(vec_take), .vec_rdata(vr), .vec_load_ok(ld_ok),
    .vec_take_ok(tk_ok));

  sfp_tgt_model tgt (.sys_clk(sys_clk), .rst_b(rst_b),
    .vci_cmdval(cmdval), .vci_cmdack(cmdack), .vci_address(vaddr),
    .vci_be(be), .vci_cmd(cmd), .vci_wdata(wdata), .vci_eop(eop),
    .vci_rspval(rspval), .vci_rspack(rspack), .vci_rdata(rdata),
    .slow(slow));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // helpers
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [15:0] dd);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= ad;
    dat_i <= {16'h0000, dd};
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic idle();
    do wb(1'b0, OFS_STAT, 16'h0000); while (q[STAT_ACT] !== 1'b0);
  endtask

  task automatic cmp_w(input logic [24:0] m);
    chk("write count", ew.size(), tgt.wq.size());
    for (k = 0; k < ew.size() && k < tgt.wq.size(); k++)
      chk("write entry", ew[k] & m, tgt.wq[k] & m);
    ew.delete();
    tgt.wq.delete();
  endtask

  function automatic logic [15:0] rd_exp(input logic [15:0] c,
                                         input logic bm);
    logic [15:0] v;
    v = 16'ha000 ^ c;
    return bm ? {8'h00, v[7:0]} : v;
  endfunction

  function automatic logic [24:0] wr_exp(input logic e, bm,
    input logic [5:0] ta, input logic [15:0] dd);
    return {e, bm ? BE_BYTE : BE_WORD, ta, dd};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    {cyc, stb, we, slow, vec_load, vec_take, out_rq, in_rq} = 8'h00;
    adr = 8'h00;
    dat_i = 32'h0000_0000;
    vw = '0;
    nrd = 16'h0000;
    void'($urandom(32'h0000_f21d));
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, OFS_CTRL, 16'h0000);
    chk("ctrl", CTRL_RST, q);
    wb(1'b0, OFS_STAT, 16'h0000);
    chk("stat", STAT_RST, q);
    wb(1'b0, OFS_TGT, 16'h0000);
    chk("tgt", TGT_RST, q);
    wb(1'b0, 8'h10, 16'h0000);
    chk("unmapped", 32'h0, q);
    chk("ep", 2'b10, ep);
    wb(1'b1, OFS_CTRL, 16'h0001);
    wb(1'b1, OFS_CTRL, 16'h0107);
    wb(1'b0, OFS_CTRL, 16'h0000);
    chk("ctrl lock", 16'h0101, q);
    chk("ep", 2'b01, ep);
    wb(1'b1, OFS_CTRL, 16'h0000);
    // single word and byte transfers
    for (i = 0; i < 6; i++)
    begin
      a = 6'($urandom_range(63));
      b = 1'($urandom_range(1));
      d = 16'($urandom);
      slow <= i[0];
      wb(1'b1, OFS_TGT, {10'h000, a});
      wb(1'b1, OFS_CTRL, {13'h0040, b, 2'b01});
      wb(1'b0, OFS_STAT, 16'h0000);
      chk("idle", 32'h0, q[STAT_ACT]);
      ew.push_back(wr_exp(1'b1, b, a, d));
      wb(1'b1, OFS_FIFO, d);
      idle();
      cmp_w({9'h1ff, {8{~b}}, 8'hff});
      wb(1'b0, OFS_FIFO, 16'h0000);
      chk("normal read", rd_exp(nrd, b), q);
      nrd++;
      wb(1'b1, OFS_CTRL, 16'h0000);
    end
    // burst read of 2*(np+1) packets
    np = 4'($urandom_range(1));
    slow <= 1'b1;
    wb(1'b1, OFS_TGT, 16'h0005);
    wb(1'b1, OFS_CTRL, {8'h02, np, 4'h3});
    n = 16 * (int'(np) + 1);
    for (i = 0; i < n - 8; i++)
    begin
      wb(1'b0, OFS_STAT, 16'h0000);
      chk("last early", 32'h0, q[STAT_LAST]);
      wb(1'b0, OFS_FIFO, 16'h0000);
      chk("burst read", rd_exp(nrd, 1'b0), q);
      nrd++;
    end
    // final packet leaves over the vectored bus
    do wb(1'b0, OFS_STAT, 16'h0000); while (q[STAT_FULL] !== 1'b1);
    chk("full", 32'h6, q[STAT_LAST:STAT_EMPTY]);
    vec_take <= 1'b1;
    do @(posedge sys_clk); while (tk_ok !== 1'b1);
    vv = vr;
    vec_take <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      chk("vector take", rd_exp(nrd, 1'b0), vv[16*i+:16]);
      nrd++;
    end
    wb(1'b0, OFS_STAT, 16'h0000);
    chk("last", 32'h1, q[STAT_LAST]);
    wb(1'b1, OFS_STAT, 16'h0008);
    wb(1'b0, OFS_STAT, 16'h0000);
    chk("last clear", 32'h0, q[STAT_LAST]);
    idle();
    chk("read count", nrd, tgt.nrd);
    wb(1'b1, OFS_CTRL, 16'h0000);
    // burst write, then a vectored load
    wb(1'b1, OFS_TGT, 16'h0021);
    wb(1'b1, OFS_CTRL, 16'h0203);
    for (i = 0; i < 8; i++)
    begin
      d = 16'($urandom);
      ew.push_back(wr_exp(1'(i == 7), 1'b0, 6'h21, d));
      wb(1'b1, OFS_FIFO, d);
      if (i == 0)
      begin
        wb(1'b0, OFS_STAT, 16'h0000);
        chk("act", 2'b10, {q[STAT_ACT], q[STAT_EMPTY]});
      end
    end
    idle();
    cmp_w(25'h1ff_ffff);
    for (i = 0; i < 8; i++)
    begin
      d = 16'($urandom);
      vv[16*i+:16] = d;
      ew.push_back(wr_exp(1'(i == 7), 1'b0, 6'h21, d));
    end
    vw <= vv;
    vec_load <= 1'b1;
    do @(posedge sys_clk); while (ld_ok !== 1'b1);
    vec_load <= 1'b0;
    @(posedge sys_clk);
    idle();
    cmp_w(25'h1ff_ffff);
    wb(1'b1, OFS_CTRL, 16'h0000);
    // usb request levels in status
    for (i = 0; i < 4; i++)
    begin
      out_rq <= i[1];
      in_rq  <= i[0];
      repeat (4) @(posedge sys_clk);
      wb(1'b0, OFS_STAT, 16'h0000);
      chk("status", {10'h000, i[1], i[0], 4'h1}, q);
    end
    end_sim();
  end
endmodule
